// [hdl/blp_cfg.svh]
`ifndef BLP_CFG_SVH
`define BLP_CFG_SVH

// clock and dwell timing
`define BLP_CLK_PERIOD_NS  20
`define BLP_STEP_NS        1000
`define BLP_STEP_CYCLES    ((`BLP_STEP_NS + `BLP_CLK_PERIOD_NS - 1) / `BLP_CLK_PERIOD_NS)
`define BLP_CNT_W          6

// reduced cpu clock, in kHz
`define BLP_SLOW_CLK_KHZ   9200

// synchroniser lanes and their idle levels
`define BLP_SYNC_LANES     5
`define BLP_LANE_SLOW      0
`define BLP_LANE_SLEEP     1
`define BLP_LANE_SUSP      2
`define BLP_LANE_EXT       3
`define BLP_LANE_BTN       4
`define BLP_SYNC_RST       5'h07

`endif

// [hdl/blp_pkg.sv]
package blp_pkg;

   typedef enum logic [2:0]
   {
      BLP_HIGH_SPEED = 3'h0,
      BLP_LOW_SPEED  = 3'h1,
      BLP_DOZE       = 3'h2,
      BLP_SLEEP      = 3'h3,
      BLP_SUSPEND    = 3'h4
   } blp_mode_t;

endpackage

// [hdl/blp_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module blp_sync
#(
   parameter logic RST_VAL = 1'b0
)
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // pin in, filtered level out
   input  wire logic pin_in,
   output var  logic level_r
);

   logic ff1_r;
   logic ff2_r;
   logic ff3_r;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ff1_r <= RST_VAL;
         ff2_r <= RST_VAL;
         ff3_r <= RST_VAL;
      end
      else
      begin
         ff1_r <= pin_in;
         ff2_r <= ff1_r;
         ff3_r <= ff2_r;
      end
   end

   // take a new level once two stages agree
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         level_r <= RST_VAL;
      end
      else if (ff2_r == ff3_r)
      begin
         level_r <= ff3_r;
      end
   end

endmodule

`default_nettype wire

// [hdl/blp_transitions.sv]
// How it works
// - first low-battery input, enabled, forces cpu clock to fixed 9.2 MHz while the unit is in High Speed.
// - second low-battery input, enabled, drives the unit into Sleep.
// - third low-battery input, enabled, drives the unit into Suspend.
// - each of the three transitions has its own enable mask.
// - levels of first two battery inputs and external power are readable.
// - battery inputs act only while external power reads absent.
// - external power rising after a battery transition returns to High Speed.
// - battery entry from High Speed walks Low Speed, then Doze, then the target mode; Sleep goes straight to Suspend.
// - in Sleep or Suspend, button press or power toggle wakes to High Speed.
// - Sleep stops cpu and high-speed pll; low-speed pll follows a config bit.
`timescale 1ns/10ps
`default_nettype none
`include "blp_cfg.svh"

module blp_transitions
(
   // clock and reset
   input  wire logic            clock,
   input  wire logic            rst_n,
   // pins from battery monitor, adapter detector and resume button
   input  wire logic            batt_low_slow_n,
   input  wire logic            batt_low_sleep_n,
   input  wire logic            batt_low_suspend_n,
   input  wire logic            ext_power_present,
   input  wire logic            resume_button,
   // transition enables and pll config
   input  wire logic            en_slow,
   input  wire logic            en_sleep,
   input  wire logic            en_suspend,
   input  wire logic            ls_pll_lowpwr_on,
   // readable pin levels
   output var  logic            batt_low_slow_lvl_r,
   output var  logic            batt_low_sleep_lvl_r,
   output var  logic            ext_power_lvl_r,
   // mode and clock controls
   output var  logic [2:0]      pmu_mode_r,
   output var  logic            cpu_slow_force_r,
   output var  logic            cpu_clk_en_r,
   output var  logic            hs_pll_en_r,
   output var  logic            ls_pll_en_r
);

   localparam logic [`BLP_CNT_W-1:0] STEP_LAST = `BLP_CNT_W'(`BLP_STEP_CYCLES - 1);

   logic [`BLP_SYNC_LANES-1:0] raw;
   logic [`BLP_SYNC_LANES-1:0] syn;

   blp_pkg::blp_mode_t mode_r;
   blp_pkg::blp_mode_t mode_nxt;
   blp_pkg::blp_mode_t tgt_r;
   blp_pkg::blp_mode_t tgt_nxt;
   blp_pkg::blp_mode_t want;
   logic [`BLP_CNT_W-1:0] cnt_r;
   logic [`BLP_CNT_W-1:0] cnt_nxt;
   logic                  caused_r;
   logic                  caused_nxt;
   logic                  ext_prev_r;
   logic                  btn_prev_r;
   logic                  ext_absent;
   logic                  slow_act;
   logic                  sleep_act;
   logic                  susp_act;
   logic                  ext_rise;
   logic                  ext_tog;
   logic                  btn_rise;

   function automatic blp_pkg::blp_mode_t deeper(input blp_pkg::blp_mode_t a, input blp_pkg::blp_mode_t b);
      deeper = (a > b) ? a : b;
   endfunction

   assign raw[`BLP_LANE_SLOW]  = batt_low_slow_n;
   assign raw[`BLP_LANE_SLEEP] = batt_low_sleep_n;
   assign raw[`BLP_LANE_SUSP]  = batt_low_suspend_n;
   assign raw[`BLP_LANE_EXT]   = ext_power_present;
   assign raw[`BLP_LANE_BTN]   = resume_button;

   // pin synchronisers
   genvar gi;
   generate
      for (gi = 0; gi < `BLP_SYNC_LANES; gi = gi + 1)
      begin : g_sync
         blp_sync
         #(
            .RST_VAL (1'(`BLP_SYNC_RST >> gi))
         )
         u_sync
         (
            .clock   (clock),
            .rst_n   (rst_n),
            .pin_in  (raw[gi]),
            .level_r (syn[gi])
         );
      end
   endgenerate

   assign ext_absent = ~syn[`BLP_LANE_EXT];
   assign slow_act   = ~syn[`BLP_LANE_SLOW] & en_slow & ext_absent;
   assign sleep_act  = ~syn[`BLP_LANE_SLEEP] & en_sleep & ext_absent;
   assign susp_act   = ~syn[`BLP_LANE_SUSP] & en_suspend & ext_absent;
   assign ext_rise   = syn[`BLP_LANE_EXT] & ~ext_prev_r;
   assign ext_tog    = syn[`BLP_LANE_EXT] ^ ext_prev_r;
   assign btn_rise   = syn[`BLP_LANE_BTN] & ~btn_prev_r;

   // deepest request wins
   always_comb
   begin
      want = blp_pkg::BLP_HIGH_SPEED;
      if (susp_act)
      begin
         want = blp_pkg::BLP_SUSPEND;
      end
      else if (sleep_act)
      begin
         want = blp_pkg::BLP_SLEEP;
      end
   end

   // mode sequencer
   always_comb
   begin
      mode_nxt   = mode_r;
      tgt_nxt    = tgt_r;
      cnt_nxt    = cnt_r;
      caused_nxt = caused_r;
      case (mode_r)
         blp_pkg::BLP_HIGH_SPEED:
         begin
            if (want != blp_pkg::BLP_HIGH_SPEED)
            begin
               mode_nxt   = blp_pkg::BLP_LOW_SPEED;
               tgt_nxt    = want;
               cnt_nxt    = '0;
               caused_nxt = 1'b1;
            end
         end
         blp_pkg::BLP_LOW_SPEED,
         blp_pkg::BLP_DOZE:
         begin
            tgt_nxt = deeper(tgt_r, want);
            if (caused_r && ext_rise)
            begin
               mode_nxt   = blp_pkg::BLP_HIGH_SPEED;
               caused_nxt = 1'b0;
            end
            else if (cnt_r == STEP_LAST)
            begin
               cnt_nxt  = '0;
               mode_nxt = (mode_r == blp_pkg::BLP_LOW_SPEED) ? blp_pkg::BLP_DOZE : deeper(tgt_r, want);
            end
            else
            begin
               cnt_nxt = `BLP_CNT_W'(cnt_r + 1'b1);
            end
         end
         blp_pkg::BLP_SLEEP,
         blp_pkg::BLP_SUSPEND:
         begin
            if (btn_rise || ext_tog || (caused_r && ext_rise))
            begin
               mode_nxt   = blp_pkg::BLP_HIGH_SPEED;
               caused_nxt = 1'b0;
            end
            else if (mode_r == blp_pkg::BLP_SLEEP && susp_act)
            begin
               mode_nxt = blp_pkg::BLP_SUSPEND;
               tgt_nxt  = blp_pkg::BLP_SUSPEND;
            end
         end
         default:
         begin
            mode_nxt   = blp_pkg::BLP_HIGH_SPEED;
            caused_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_r   <= blp_pkg::BLP_HIGH_SPEED;
         tgt_r    <= blp_pkg::BLP_HIGH_SPEED;
         cnt_r    <= '0;
         caused_r <= 1'b0;
      end
      else
      begin
         mode_r   <= mode_nxt;
         tgt_r    <= tgt_nxt;
         cnt_r    <= cnt_nxt;
         caused_r <= caused_nxt;
      end
   end

   // edge history
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_prev_r <= 1'b0;
         btn_prev_r <= 1'b0;
      end
      else
      begin
         ext_prev_r <= syn[`BLP_LANE_EXT];
         btn_prev_r <= syn[`BLP_LANE_BTN];
      end
   end

   // readable levels
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         batt_low_slow_lvl_r  <= 1'b1;
         batt_low_sleep_lvl_r <= 1'b1;
         ext_power_lvl_r      <= 1'b0;
      end
      else
      begin
         batt_low_slow_lvl_r  <= syn[`BLP_LANE_SLOW];
         batt_low_sleep_lvl_r <= syn[`BLP_LANE_SLEEP];
         ext_power_lvl_r      <= syn[`BLP_LANE_EXT];
      end
   end

   // clock and pll controls from next mode
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pmu_mode_r       <= 3'h0;
         cpu_slow_force_r <= 1'b0;
         cpu_clk_en_r     <= 1'b1;
         hs_pll_en_r      <= 1'b1;
         ls_pll_en_r      <= 1'b1;
      end
      else
      begin
         pmu_mode_r       <= mode_nxt;
         cpu_slow_force_r <= slow_act && (mode_nxt == blp_pkg::BLP_HIGH_SPEED);
         cpu_clk_en_r     <= (mode_nxt == blp_pkg::BLP_HIGH_SPEED) || (mode_nxt == blp_pkg::BLP_LOW_SPEED);
         hs_pll_en_r      <= (mode_nxt == blp_pkg::BLP_HIGH_SPEED) || (mode_nxt == blp_pkg::BLP_LOW_SPEED);
         ls_pll_en_r      <= (mode_nxt == blp_pkg::BLP_HIGH_SPEED) || (mode_nxt == blp_pkg::BLP_LOW_SPEED) ||
                             ls_pll_lowpwr_on;
      end
   end

endmodule

`default_nettype wire

// [verification/blp_transitions_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module blp_chk
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // pins and controls
   input  wire logic       batt_low_slow_n,
   input  wire logic       ext_power_present,
   input  wire logic       resume_button,
   input  wire logic       en_slow,
   input  wire logic       ls_pll_lowpwr_on,
   // block outputs
   input  wire logic       batt_low_slow_lvl_r,
   input  wire logic       ext_power_lvl_r,
   input  wire logic [2:0] pmu_mode_r,
   input  wire logic       cpu_slow_force_r,
   input  wire logic       cpu_clk_en_r,
   input  wire logic       hs_pll_en_r,
   input  wire logic       ls_pll_en_r
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   property p_force;
      cpu_slow_force_r |-> pmu_mode_r == 3'h0 && $past(en_slow);
   endproperty
   a_force: assert property (p_force) else $error("slow force outside high speed");
   property p_slow_lvl;
      $fell(batt_low_slow_n) ##1 !batt_low_slow_n [*5] |-> !batt_low_slow_lvl_r;
   endproperty
   a_slow_lvl: assert property (p_slow_lvl) else $error("slow level not seen");
   property p_ext_lvl;
      $rose(ext_power_present) ##1 ext_power_present [*5] |-> ext_power_lvl_r;
   endproperty
   a_ext_lvl: assert property (p_ext_lvl) else $error("ext level not seen");
   property p_clk;
      cpu_clk_en_r == hs_pll_en_r && cpu_clk_en_r == (pmu_mode_r < 3'h2);
   endproperty
   a_clk: assert property (p_clk) else $error("cpu clock or pll wrong for mode");
   property p_ls;
      $stable(ls_pll_lowpwr_on) |-> ls_pll_en_r == (pmu_mode_r < 3'h2 || ls_pll_lowpwr_on);
   endproperty
   a_ls: assert property (p_ls) else $error("low speed pll wrong");
   property p_order;
      $changed(pmu_mode_r) && pmu_mode_r >= 3'h1 |->
         $past(pmu_mode_r) == pmu_mode_r - 3'h1 || (pmu_mode_r == 3'h4 && $past(pmu_mode_r) == 3'h2);
   endproperty
   a_order: assert property (p_order) else $error("mode skipped a step");
   property p_ext_hold;
      (pmu_mode_r == 3'h0) ##1 ext_power_lvl_r |-> pmu_mode_r == 3'h0;
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("mode left with ext power");
   property p_wake;
      $rose(ext_power_lvl_r) |-> ##[0:2] pmu_mode_r == 3'h0;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on ext power");
   property p_button;
      pmu_mode_r >= 3'h3 && $rose(resume_button) |-> ##[2:7] pmu_mode_r == 3'h0;
   endproperty
   a_button: assert property (p_button) else $error("no wake on button");
endmodule
`default_nettype wire

// [verification/blp_batt_mon.sv]
`timescale 1ns/10ps
`default_nettype none
module blp_batt_mon
(
   // conditions: slow, sleep, suspend, ext power
   input  wire logic [3:0] cond,
   // pins toward the block
   output wire logic       batt_low_slow_n,
   output wire logic       batt_low_sleep_n,
   output wire logic       batt_low_suspend_n,
   output wire logic       ext_power_present
);
   // thresholds pulled low and held while the condition lasts
   assign batt_low_slow_n    = !cond[0];
   assign batt_low_sleep_n   = !cond[1];
   assign batt_low_suspend_n = !cond[2];
   assign ext_power_present  = cond[3];
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic       clock, rst_n, btn, en_slow, en_sleep, en_susp, cfg;
   logic       bl1_n, bl2_n, bl4_n, ext, l1, l2, le, frc, cpu, hs, ls;
   logic [3:0] cond;
   logic [2:0] mode;
   int         errors, tests_run, cycles;
   blp_batt_mon blp_batt_mon_i (.cond(cond), .batt_low_slow_n(bl1_n), .batt_low_sleep_n(bl2_n),
      .batt_low_suspend_n(bl4_n), .ext_power_present(ext));
   blp_transitions blp_transitions_i (.clock(clock), .rst_n(rst_n), .batt_low_slow_n(bl1_n),
      .batt_low_sleep_n(bl2_n), .batt_low_suspend_n(bl4_n), .ext_power_present(ext),
      .resume_button(btn), .en_slow(en_slow), .en_sleep(en_sleep), .en_suspend(en_susp),
      .ls_pll_lowpwr_on(cfg), .batt_low_slow_lvl_r(l1), .batt_low_sleep_lvl_r(l2),
      .ext_power_lvl_r(le), .pmu_mode_r(mode), .cpu_slow_force_r(frc), .cpu_clk_en_r(cpu),
      .hs_pll_en_r(hs), .ls_pll_en_r(ls));
   task automatic final_report;
      if (errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wait_mode(input logic [2:0] m);
      int n;
      n = 0;
      while (mode !== m && n < 200)
      begin
         cyc(1);
         n++;
      end
      chk(mode, m);
   endtask
   // pins idle, ext power pulse brings the block home
   task automatic idle;
      cond = 4'h8;
      btn = 1'b0;
      cyc(12);
      cond = 4'h0;
      cyc(12);
   endtask
   task automatic t_slow;
      {en_slow, en_sleep, en_susp} = 3'h4;
      cond = 4'h1;
      cyc(8);
      chk(frc, 1'b1);
      chk(l1, 1'b0);
      cond = 4'h9;
      cyc(8);
      chk(frc, 1'b0);
      chk(le, 1'b1);
      idle();
   endtask
   task automatic t_mask;
      {en_slow, en_sleep, en_susp} = 3'h0;
      cond = 4'h7;
      cyc(150);
      chk(mode, 3'h0);
      chk(frc, 1'b0);
      idle();
   endtask
   task automatic t_sleep;
      {en_slow, en_sleep, en_susp} = 3'h2;
      cfg = 1'b0;
      cond = 4'h2;
      wait_mode(3'h1);
      chk(cpu, 1'b1);
      wait_mode(3'h2);
      chk(ls, 1'b0);
      wait_mode(3'h3);
      chk({cpu, hs}, 2'h0);
      chk(l2, 1'b0);
      en_susp = 1'b1;
      cond = 4'h6;
      wait_mode(3'h4);
      cond = 4'hA;
      wait_mode(3'h0);
      cyc(20);
      chk(mode, 3'h0);
      idle();
   endtask
   task automatic t_susp;
      {en_slow, en_sleep, en_susp} = 3'h3;
      cfg = 1'b1;
      cond = 4'h6;
      wait_mode(3'h2);
      cyc(60);
      chk(mode, 3'h4);
      chk(ls, 1'b1);
      btn = 1'b1;
      wait_mode(3'h0);
      idle();
   endtask
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         final_report();
      end
   end
   initial
   begin
      {rst_n, btn, en_slow, en_sleep, en_susp, cfg, cond} = 10'h0;
      cyc(2);
      rst_n = 1'b1;
      chk({mode, cpu, l1, le}, 6'h06);
      t_slow();
      t_mask();
      t_sleep();
      t_susp();
      final_report();
   end
endmodule
bind blp_transitions blp_chk blp_chk_i (.clock(clock), .rst_n(rst_n), .batt_low_slow_n(batt_low_slow_n),
   .ext_power_present(ext_power_present), .resume_button(resume_button), .en_slow(en_slow),
   .ls_pll_lowpwr_on(ls_pll_lowpwr_on), .batt_low_slow_lvl_r(batt_low_slow_lvl_r),
   .ext_power_lvl_r(ext_power_lvl_r), .pmu_mode_r(pmu_mode_r), .cpu_slow_force_r(cpu_slow_force_r),
   .cpu_clk_en_r(cpu_clk_en_r), .hs_pll_en_r(hs_pll_en_r), .ls_pll_en_r(ls_pll_en_r));
`default_nettype wire
